// ===== verilog/emt_map.svh
// Constants for the eight-bit match timer channel
`ifndef EMT_MAP_SVH
`define EMT_MAP_SVH
`define EMT_CNT_W        8
`define EMT_CNT_MAX      8'hFF
`define EMT_CNT_ZERO     8'h00
`define EMT_CONST_RST    8'hFF
`define EMT_PRE_W        12
`define EMT_OSEL_NONE    2'h0
`define EMT_OSEL_LOW     2'h1
`define EMT_OSEL_HIGH    2'h2
`define EMT_OSEL_TOGGLE  2'h3
`define EMT_CLR_NONE     2'h0
`define EMT_CLR_MATCH_A  2'h1
`define EMT_CLR_MATCH_B  2'h2
`define EMT_CLR_EXT      2'h3
`define EMT_CKS_STOP     3'h0
`define EMT_CKS_EXT_RISE 3'h5
`define EMT_CKS_EXT_FALL 3'h6
`define EMT_CKS_EXT_BOTH 3'h7
`endif

// ===== verilog/emt_pkg.sv
// Types shared by the eight-bit match timer channel
package emt_pkg;
  // Configuration carried as one group
  typedef struct packed {
    logic [2:0] clock_select;      // clock_select_hi .. clock_select_lo
    logic [1:0] aux_clock_select;  // aux_clock_select_hi/lo
    logic [1:0] clear_sel;         // clear_sel_hi, clear_sel_lo
    logic [1:0] out_sel_b;         // out_sel_b_hi, lo
    logic [1:0] out_sel_a;         // hi, out_sel_a_lo
    logic       match_irq_en_a;
    logic       match_irq_en_b;
    logic       wrap_irq_en;
  } emt_cfg_t;
  // Flag state seen by software
  typedef struct packed {
    logic match_flag_b;
    logic match_flag_a;
    logic wrap_flag;
  } emt_flags_t;
  // Software flag-clear requests (write of zero after a read of one)
  typedef struct packed {
    logic clr_b;
    logic clr_a;
    logic clr_wrap;
  } emt_fclr_t;
endpackage

// ===== verilog/emt_flag.sv
// One sticky event flag with read-then-write-zero clearing
`timescale 1ns/10ps
module emt_flag
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_set,
  input  wire logic i_read,
  input  wire logic i_clear,
  output logic      o_flag
);
  logic armed;

  // Arm on a read that sees the flag set; a later clear then counts
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      armed <= 1'b0;
    else if (i_set)
      armed <= armed;
    else if (i_clear)
      armed <= 1'b0;
    else if (i_read && o_flag)
      armed <= 1'b1;
  end

  // set wins
  // Set beats clear so an event in the clear cycle is kept
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_flag <= 1'b0;
    else if (i_set)
      o_flag <= 1'b1;
    else if (i_clear && armed)
      o_flag <= 1'b0;
  end

  flag_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ($past(o_flag) && !o_flag) |-> $past(armed))
    else $error("flag cleared without prior read");
endmodule // emt_flag

// ===== verilog/emt_timer.sv
// Eight-bit match timer channel: counter, compares, output, flags
`timescale 1ns/10ps
`include "emt_map.svh"
module emt_timer
#(
  parameter int CNT_W = `EMT_CNT_W
)
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire emt_pkg::emt_cfg_t    i_cfg,
  input  wire logic                 i_ext_count_input,
  input  wire logic                 i_ext_reset_input,
  input  wire logic                 i_cnt_wr,
  input  wire logic [CNT_W-1:0]     i_cnt_wdata,
  input  wire logic                 i_const_a_wr,
  input  wire logic                 i_const_b_wr,
  input  wire logic [CNT_W-1:0]     i_const_wdata,
  input  wire logic                 i_flag_rd,
  input  wire emt_pkg::emt_fclr_t   i_flag_clr,
  output logic [CNT_W-1:0]          o_up_counter,
  output logic [CNT_W-1:0]          o_match_constant_a,
  output logic [CNT_W-1:0]          o_match_constant_b,
  output emt_pkg::emt_flags_t       o_flags,
  output logic                      o_timer_out,
  output logic                      o_timer_out_en,
  output logic                      o_match_irq_a,
  output logic                      o_match_irq_b,
  output logic                      o_wrap_irq,
  output logic [1:0]                o_irq_top
);
  import emt_pkg::*;

  logic [`EMT_PRE_W-1:0] prescale;
  logic [2:0]            ext_sync;
  logic [2:0]            rst_sync;
  logic                  pre_tap;
  logic                  pre_tap_d;
  logic                  tick;
  logic                  ext_rise;
  logic                  ext_fall;
  logic                  ext_clr;
  logic                  match_a;
  logic                  match_b;
  logic                  clr_cnt;
  logic                  wrap;
  logic [1:0]            act;
  logic                  next_out;

  // Free-running prescaler shared by all internal sources
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      prescale <= '0;
    else
      prescale <= prescale + 1'b1;
  end

  // prescaler tap
  // Six taps chosen by the main and aux select fields
  always_comb
  begin
    case (i_cfg.clock_select)
      3'h1:    pre_tap = i_cfg.aux_clock_select[1] ? prescale[1] : prescale[2];
      3'h2:    pre_tap = i_cfg.aux_clock_select[1] ? prescale[4] : prescale[5];
      3'h3:    pre_tap = i_cfg.aux_clock_select[0] ? prescale[9] : prescale[10];
      default: pre_tap = 1'b0;
    endcase
  end

  // Two-flop synchronisers; the third stage is the edge history
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ext_sync  <= '0;
      rst_sync  <= '0;
      pre_tap_d <= 1'b0;
    end
    else
    begin
      ext_sync  <= {ext_sync[1:0], i_ext_count_input};
      rst_sync  <= {rst_sync[1:0], i_ext_reset_input};
      pre_tap_d <= pre_tap;
    end
  end

  assign ext_rise = ext_sync[1] && !ext_sync[2];
  assign ext_fall = !ext_sync[1] && ext_sync[2];
  assign ext_clr  = (i_cfg.clear_sel == `EMT_CLR_EXT)
                    && rst_sync[1] && !rst_sync[2];

  // count pulse
  // Short external levels are missed by the synchroniser, hence the
  // minimum pulse widths demanded of the source
  always_comb
  begin
    case (i_cfg.clock_select)
      `EMT_CKS_STOP:     tick = 1'b0;
      `EMT_CKS_EXT_RISE: tick = ext_rise;
      `EMT_CKS_EXT_FALL: tick = ext_fall;
      `EMT_CKS_EXT_BOTH: tick = ext_rise || ext_fall;
      default:           tick = pre_tap_d && !pre_tap;
    endcase
  end

  // match strobes
  // Match fires on the last cycle of equality, never while its own constant is written
  assign match_a = tick && (o_up_counter == o_match_constant_a)
                   && !i_const_a_wr;
  assign match_b = tick && (o_up_counter == o_match_constant_b)
                   && !i_const_b_wr;

  assign clr_cnt = ext_clr
                   || (i_cfg.clear_sel == `EMT_CLR_MATCH_A && match_a)
                   || (i_cfg.clear_sel == `EMT_CLR_MATCH_B && match_b);
  // wrap detect; a clear or a software write replaces the wrap
  assign wrap = tick && !clr_cnt && !i_cnt_wr
                && (o_up_counter == `EMT_CNT_MAX);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_up_counter <= `EMT_CNT_ZERO;
    else if (clr_cnt)
      o_up_counter <= `EMT_CNT_ZERO;
    else if (i_cnt_wr)
      o_up_counter <= i_cnt_wdata;
    else if (tick)
      o_up_counter <= o_up_counter + 1'b1;
  end

  // Constant registers written by software
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_match_constant_a <= `EMT_CONST_RST;
      o_match_constant_b <= `EMT_CONST_RST;
    end
    else
    begin
      if (i_const_a_wr)
        o_match_constant_a <= i_const_wdata;
      if (i_const_b_wr)
        o_match_constant_b <= i_const_wdata;
    end
  end

  // output action
  // Largest code wins: toggle, high, low, hold in that order
  always_comb
  begin
    act = `EMT_OSEL_NONE;
    if (match_a && i_cfg.out_sel_a > act)
      act = i_cfg.out_sel_a;
    if (match_b && i_cfg.out_sel_b > act)
      act = i_cfg.out_sel_b;
    case (act)
      `EMT_OSEL_LOW:    next_out = 1'b0;
      `EMT_OSEL_HIGH:   next_out = 1'b1;
      `EMT_OSEL_TOGGLE: next_out = !o_timer_out;
      default:          next_out = o_timer_out;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_timer_out <= 1'b0;
    else
      o_timer_out <= next_out;
  end

  assign o_timer_out_en = |{i_cfg.out_sel_a, i_cfg.out_sel_b};

  emt_flag u_flag_a
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_set   (match_a),
    .i_read  (i_flag_rd),
    .i_clear (i_flag_clr.clr_a),
    .o_flag  (o_flags.match_flag_a)
  );
  emt_flag u_flag_b
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_set   (match_b),
    .i_read  (i_flag_rd),
    .i_clear (i_flag_clr.clr_b),
    .o_flag  (o_flags.match_flag_b)
  );
  emt_flag u_flag_w
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_set   (wrap),
    .i_read  (i_flag_rd),
    .i_clear (i_flag_clr.clr_wrap),
    .o_flag  (o_flags.wrap_flag)
  );

  assign o_match_irq_a = o_flags.match_flag_a && i_cfg.match_irq_en_a;
  assign o_match_irq_b = o_flags.match_flag_b && i_cfg.match_irq_en_b;
  assign o_wrap_irq    = o_flags.wrap_flag && i_cfg.wrap_irq_en;

  // priority code
  // 3 = match A, 2 = match B, 1 = wrap, 0 = none
  always_comb
  begin
    if (o_match_irq_a)
      o_irq_top = 2'h3;
    else if (o_match_irq_b)
      o_irq_top = 2'h2;
    else if (o_wrap_irq)
      o_irq_top = 2'h1;
    else
      o_irq_top = 2'h0;
  end

  // Checks beside the logic
  match_flag_a_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    match_a |=> o_flags.match_flag_a)
    else $error("match A did not set flag");
  write_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_const_a_wr |-> !match_a)
    else $error("match A during constant write");
  wrap_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (tick && !clr_cnt && !i_cnt_wr && o_up_counter == 8'hFF)
    |=> (o_up_counter == 8'h00) && o_flags.wrap_flag)
    else $error("wrap not flagged");
  clear_win_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (clr_cnt && i_cnt_wr) |=> o_up_counter == 8'h00)
    else $error("write beat clear");
  clear_a_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (match_a && i_cfg.clear_sel == 2'h1) |=> o_up_counter == 8'h00)
    else $error("match A clear missed");
  clear_b_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (match_b && i_cfg.clear_sel == 2'h2) |=> o_up_counter == 8'h00)
    else $error("match B clear missed");
  ext_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_cfg.clear_sel == 2'h3 && $rose(rst_sync[1]))
    |=> o_up_counter == 8'h00)
    else $error("external clear missed");
  toggle_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (match_a && i_cfg.out_sel_a == 2'h3)
    |=> o_timer_out != $past(o_timer_out))
    else $error("toggle not applied");
  out_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (match_a && i_cfg.out_sel_a == 2'h2 && !(match_b
     && i_cfg.out_sel_b == 2'h3)) |=> o_timer_out)
    else $error("drive high not applied");
  out_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!match_a && !match_b) |=> $stable(o_timer_out))
    else $error("output changed without match");
  irq_prio_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_match_irq_a |-> o_irq_top == 2'h3)
    else $error("priority wrong");
  irq_line_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_wrap_irq == (o_flags.wrap_flag && i_cfg.wrap_irq_en))
    else $error("wrap request mismatch");
  ext_tick_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_cfg.clock_select == 3'h5 && ext_rise && !clr_cnt && !i_cnt_wr)
    |=> o_up_counter == $past(o_up_counter) + 8'h01)
    else $error("external rise not counted");
  int_tick_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (tick && i_cfg.clock_select == 3'h1 && $stable(i_cfg))
    |-> prescale[1:0] == 2'h0)
    else $error("internal tick off the prescaler fall");
endmodule // emt_timer

// ===== test/emt_pin_model.sv
// Far-side pin model: external count and external counter-reset pins
`timescale 1ns/10ps
module emt_pin_model
(
  input  wire logic i_clk,
  output logic      o_ext_count_input,
  output logic      o_ext_reset_input
);
  // Both pins rest low outside the bursts the bench asks for
  initial
  begin
    o_ext_count_input = 1'b0;
    o_ext_reset_input = 1'b0;
  end
  // levels held three clocks each
  // Three clocks clears the both-edge minimum with margin for the synchroniser
  task automatic count_pulses(input int n);
    for (int i = 0; i < n; i++)
    begin
      repeat (3) @(negedge i_clk);
      o_ext_count_input = 1'b1;
      repeat (3) @(negedge i_clk);
      o_ext_count_input = 1'b0;
    end
    repeat (4) @(negedge i_clk);  // Let the last edge cross the syncs
  endtask
  task automatic reset_pulse();
    @(negedge i_clk);
    o_ext_reset_input = 1'b1;
    repeat (3) @(negedge i_clk);
    o_ext_reset_input = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
endmodule // emt_pin_model

// ===== test/test_eight_bit_match_timer.sv
// Self-checking bench for the eight-bit match timer channel
`timescale 1ns/10ps
`include "emt_map.svh"
module test_eight_bit_match_timer;
  import emt_pkg::*;
  logic        i_clk;
  logic        i_rst_n;
  emt_cfg_t    cfg;
  emt_fclr_t   flag_clr;
  emt_flags_t  flags;
  logic        ext_cnt, ext_rst, cnt_wr, ca_wr, cb_wr, flag_rd;
  logic        t_out, t_out_en, irq_a, irq_b, irq_w;
  logic [7:0]  cnt_wdata, const_wdata, up_cnt, const_a, const_b;
  logic [1:0]  irq_top;
  int          n_errors, total_checks, cycles;
  emt_timer emt_timer_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(cfg),
    .i_ext_count_input(ext_cnt), .i_ext_reset_input(ext_rst),
    .i_cnt_wr(cnt_wr), .i_cnt_wdata(cnt_wdata), .i_const_a_wr(ca_wr),
    .i_const_b_wr(cb_wr), .i_const_wdata(const_wdata), .i_flag_rd(flag_rd),
    .i_flag_clr(flag_clr), .o_up_counter(up_cnt),
    .o_match_constant_a(const_a), .o_match_constant_b(const_b),
    .o_flags(flags), .o_timer_out(t_out), .o_timer_out_en(t_out_en),
    .o_match_irq_a(irq_a), .o_match_irq_b(irq_b), .o_wrap_irq(irq_w),
    .o_irq_top(irq_top));
  emt_pin_model emt_pin_model_inst (.i_clk(i_clk),
    .o_ext_count_input(ext_cnt), .o_ext_reset_input(ext_rst));
  // Free-running 10 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // Hang guard: the slowest prescaler taps need about ten thousand cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic tick();
    @(negedge i_clk);
  endtask
  // One-cycle software strobes, all launched on the falling edge
  task automatic wr_cnt(input logic [7:0] v);
    tick();
    cnt_wr = 1'b1;
    cnt_wdata = v;
    tick();
    cnt_wr = 1'b0;
  endtask
  task automatic wr_const(input logic sel_b, input logic [7:0] v);
    tick();
    const_wdata = v;
    ca_wr = ~sel_b;
    cb_wr = sel_b;
    tick();
    ca_wr = 1'b0;
    cb_wr = 1'b0;
  endtask
  // Optional read, then a zero write to the chosen flags
  task automatic clr_flags(input logic rd, input emt_fclr_t c);
    tick();
    flag_rd = rd;
    tick();
    flag_rd = 1'b0;
    flag_clr = c;
    tick();
    flag_clr = 3'b000;
    tick();
  endtask
  // Cycles between two counter changes; the first two changes are skipped
  // since a tap switch may give one early count
  task automatic period(output int p);
    logic [7:0] c;
    for (int n = 0; n < 3; n++)
    begin
      c = up_cnt;
      p = 0;
      while (up_cnt === c && p < 3000)
      begin
        tick();
        p++;
      end
    end
  endtask
  task automatic test_reset();
    check(up_cnt, 8'h00, "counter after reset");
    check(const_a, `EMT_CONST_RST, "constant a after reset");
    check(const_b, `EMT_CONST_RST, "constant b after reset");
    check(flags, 3'b000, "flags after reset");
    check(t_out, 1'b0, "output after reset");
    check(irq_top, 2'b00, "no request after reset");
  endtask
  // Rise, fall and both-edge modes; three pulses in each
  task automatic test_ext_modes();
    logic [2:0] m [3] = '{`EMT_CKS_EXT_RISE, `EMT_CKS_EXT_FALL,
                          `EMT_CKS_EXT_BOTH};
    logic [7:0] e [3] = '{8'h03, 8'h06, 8'h0C};
    for (int i = 0; i < 3; i++)
    begin
      cfg.clock_select = m[i];
      emt_pin_model_inst.count_pulses(3);
      check(up_cnt, e[i], "external edge count");
    end
  endtask
  // Prescaled rate for all six internal taps
  task automatic test_internal();
    logic [2:0]  cs [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3};
    logic [1:0]  ax [6] = '{2'b10, 2'b00, 2'b10, 2'b00, 2'b01, 2'b00};
    logic [15:0] e [6] = '{16'd4, 16'd8, 16'd32, 16'd64, 16'd1024,
                           16'd2048};
    int p;
    for (int j = 0; j < 6; j++)
    begin
      cfg.clock_select = cs[j];
      cfg.aux_clock_select = ax[j];
      period(p);
      check(16'(p), e[j], "internal count period");
    end
    cfg.clock_select = `EMT_CKS_EXT_RISE;
  endtask
  task automatic test_match_clear();
    wr_cnt(8'h00);
    wr_const(1'b0, 8'h02);
    cfg.clear_sel = `EMT_CLR_MATCH_A;
    cfg.out_sel_a = `EMT_OSEL_TOGGLE;
    cfg.match_irq_en_a = 1'b1;
    emt_pin_model_inst.count_pulses(3);
    check(up_cnt, 8'h00, "cleared on match a");
    check(flags.match_flag_a, 1'b1, "match flag a");
    check(t_out, 1'b1, "toggled on match a");
    check(irq_a, 1'b1, "request a");
    check(irq_top, 2'd3, "request a on top");
    clr_flags(1'b0, 3'b010);
    check(flags.match_flag_a, 1'b1, "clear without read");
    clr_flags(1'b1, 3'b010);
    check(flags.match_flag_a, 1'b0, "clear after read");
    check(irq_a, 1'b0, "request a dropped");
  endtask
  // Every rising edge matches constant zero and clears back to zero
  task automatic test_out_decode();
    logic [1:0] s [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    logic       e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    wr_const(1'b0, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      cfg.out_sel_a = s[i];
      emt_pin_model_inst.count_pulses(1);
      check(t_out, e[i], "output select a action");
      check(t_out_en, s[i] != 2'h0, "output enable");
    end
  endtask
  task automatic test_out_conflict();
    logic [1:0] a [3] = '{2'h1, 2'h3, 2'h2};
    logic [1:0] b [3] = '{2'h3, 2'h2, 2'h1};
    logic       e [3] = '{1'b1, 1'b0, 1'b1};
    wr_const(1'b1, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      cfg.out_sel_a = a[i];
      cfg.out_sel_b = b[i];
      emt_pin_model_inst.count_pulses(1);
      check(t_out, e[i], "simultaneous match action");
    end
  endtask
  task automatic test_priority_wrap();
    cfg.match_irq_en_b = 1'b1;
    cfg.wrap_irq_en = 1'b1;
    tick();
    check(irq_top, 2'd3, "a above b");
    cfg.match_irq_en_a = 1'b0;
    tick();
    check(irq_top, 2'd2, "b when a masked");
    check(irq_b, 1'b1, "request b");
    clr_flags(1'b1, 3'b110);
    cfg.clear_sel = `EMT_CLR_NONE;
    wr_const(1'b0, 8'h10);
    wr_const(1'b1, 8'h10);
    check(const_b, 8'h10, "constant b written");
    wr_cnt(8'hFE);
    emt_pin_model_inst.count_pulses(2);
    check(up_cnt, 8'h00, "wrap to zero");
    check(flags, 3'b001, "only wrap flag");
    check(irq_top, 2'd1, "wrap request");
    check(irq_w, 1'b1, "wrap request line");
    cfg.clear_sel = `EMT_CLR_MATCH_B;
    wr_cnt(8'h0F);
    emt_pin_model_inst.count_pulses(2);
    check(up_cnt, 8'h00, "cleared on match b");
  endtask
  // pulse generation
  // Period set by constant A, high on A, low on B, no software help
  task automatic test_pulse_gen();
    cfg.clear_sel = `EMT_CLR_MATCH_A;
    cfg.out_sel_a = `EMT_OSEL_HIGH;
    cfg.out_sel_b = `EMT_OSEL_LOW;
    wr_const(1'b0, 8'h03);
    wr_const(1'b1, 8'h01);
    wr_cnt(8'h00);
    emt_pin_model_inst.count_pulses(2);
    check(t_out, 1'b0, "pulse low on match b");
    check(up_cnt, 8'h02, "count runs past b");
    emt_pin_model_inst.count_pulses(2);
    check(t_out, 1'b1, "pulse high on match a");
    check(up_cnt, 8'h00, "period restarts on a");
  endtask
  task automatic test_ext_reset();
    cfg.clear_sel = `EMT_CLR_EXT;
    wr_cnt(8'h50);
    tick();
    check(up_cnt, 8'h50, "counter written");
    emt_pin_model_inst.reset_pulse();
    check(up_cnt, 8'h00, "external reset clear");
  endtask
  // Main sequence: reset for five clocks, then each scenario in turn
  initial
  begin
    i_rst_n = 1'b0;
    cfg = '0;
    flag_clr = 3'b000;
    {cnt_wr, ca_wr, cb_wr, flag_rd} = 4'h0;
    cnt_wdata = 8'h00;
    const_wdata = 8'h00;
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    tick();
    test_reset();
    test_ext_modes();
    test_internal();
    test_match_clear();
    test_out_decode();
    test_out_conflict();
    test_priority_wrap();
    test_pulse_gen();
    test_ext_reset();
    print_verdict();
  end
endmodule // test_eight_bit_match_timer
